/* File: shared/unvs_pkg.sv */
// Constants and types for the user non-volatile register store
package unvs_pkg;
	localparam int NUM_WIDTH = 32;
	localparam int LOC_COUNT = 32;
	localparam int CHARS_PER_LOC = 4;
	localparam int CHAR_WIDTH = 8;
	localparam int IDX_WIDTH = 8;
	localparam int ADDR_WIDTH = 5;
	localparam logic [IDX_WIDTH-1:0] IDX_MIN = 8'h01;
	localparam logic [IDX_WIDTH-1:0] IDX_MAX = 8'h20;
	localparam logic [IDX_WIDTH-1:0] IDX_SUCCESS = 8'hFF;
	localparam logic [IDX_WIDTH-1:0] IDX_RESET = 8'h00;
	localparam logic [CHAR_WIDTH-1:0] NUL_CHAR = 8'h00;
	localparam logic [NUM_WIDTH-1:0] WORD_ZERO = 32'h00000000;
	localparam logic [ADDR_WIDTH-1:0] ADDR_LAST = 5'h1F;
	typedef enum logic [2:0] {
		UNVS_IDLE = 3'b000,
		UNVS_NREAD = 3'b001,
		UNVS_NWAIT = 3'b010,
		UNVS_TEXT = 3'b011,
		UNVS_TNUL = 3'b100,
		UNVS_DONE = 3'b101
	} unvs_state_t;
endpackage : unvs_pkg

/* File: design/unvs_mem.sv */
// Storage array for the user register store, registered read data
`timescale 1ns/10ps
module unvs_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];
	// No reset port: contents survive every reset
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : unvs_mem

/* File: design/unvs_store.sv */
// Top of the user register store: index select, numeric and text ports
`timescale 1ns/10ps
module unvs_store
	import unvs_pkg::*;
#(
	parameter int LOCS = LOC_COUNT
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic IDX_WR,
	input wire logic [IDX_WIDTH-1:0] IDX_WDATA,
	output logic [IDX_WIDTH-1:0] IDX_RDATA,
	input wire logic NUM_WR,
	input wire logic [NUM_WIDTH-1:0] NUM_WDATA,
	input wire logic NUM_RD,
	output logic [NUM_WIDTH-1:0] NUM_RDATA,
	output logic NUM_RVALID,
	input wire logic TXT_START,
	input wire logic TXT_VALID,
	input wire logic [CHAR_WIDTH-1:0] TXT_CHAR,
	input wire logic TXT_LAST,
	output logic TXT_READY,
	output logic BUSY,
	output logic ERR
);
	unvs_state_t state_r, state_nxt;
	logic [IDX_WIDTH-1:0] idx_r;
	logic [ADDR_WIDTH-1:0] addr_r;
	logic [1:0] pos_r;
	logic [NUM_WIDTH-1:0] chunk_r;
	logic [NUM_WIDTH-1:0] rd_word;
	logic [IDX_WIDTH-1:0] idx_out_r;
	logic [NUM_WIDTH-1:0] num_out_r;
	logic num_vld_r, ready_r, busy_r, err_r;
	logic [ADDR_WIDTH-1:0] addr_inc;
	localparam logic [1:0] POS_LAST = 2'(CHARS_PER_LOC - 1);

	wire idx_ok = (idx_r >= IDX_MIN) && (idx_r <= IDX_MAX);
	wire idx_in_ok = (IDX_WDATA >= IDX_MIN) && (IDX_WDATA <= IDX_MAX);
	wire [IDX_WIDTH-1:0] idx_zb = idx_r - IDX_MIN;
	wire [ADDR_WIDTH-1:0] sel_addr = idx_zb[ADDR_WIDTH-1:0];
	wire idle = (state_r == UNVS_IDLE) || (state_r == UNVS_DONE);
	wire char_take = (state_r == UNVS_TEXT) && TXT_VALID;
	wire is_nul = TXT_CHAR == NUL_CHAR;
	wire str_end = char_take && (TXT_LAST || is_nul);
	// Pack character into the chunk, first char in low byte
	wire [NUM_WIDTH-1:0] chunk_nxt = chunk_r | ({{(NUM_WIDTH-CHAR_WIDTH){1'b0}}, TXT_CHAR}
		<< (pos_r * CHAR_WIDTH));
	wire chunk_full = char_take && (pos_r == POS_LAST);
	// Full final chunk needs extra terminator location
	wire need_nul = str_end && chunk_full && !is_nul;
	wire at_end = addr_r == ADDR_LAST;
	assign addr_inc = addr_r + 5'h01;

	wire num_we = idle && !IDX_WR && !NUM_RD && NUM_WR && idx_ok;
	// Chunk writes at chunk boundary or string end
	wire txt_we = char_take && (chunk_full || str_end);
	wire nul_we = state_r == UNVS_TNUL;
	// Nothing written past the last location
	wire mem_we = num_we || txt_we || nul_we;
	wire [NUM_WIDTH-1:0] mem_wd = num_we ? NUM_WDATA : (nul_we ? WORD_ZERO : chunk_nxt);
	wire [ADDR_WIDTH-1:0] mem_wa = num_we ? sel_addr : addr_r;

	unvs_mem #(.WIDTH(NUM_WIDTH), .DEPTH(LOCS), .AW(ADDR_WIDTH)) u_mem (
		.clk(SYS_CLK),
		.we(mem_we),
		.waddr(mem_wa),
		.wdata(mem_wd),
		.raddr(sel_addr),
		.rdata(rd_word)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			UNVS_IDLE, UNVS_DONE: begin
				if (IDX_WR) begin
					state_nxt = UNVS_IDLE;
				end else if (NUM_RD && idx_ok) begin
					state_nxt = UNVS_NREAD;
				end else if (NUM_WR && idx_ok) begin
					state_nxt = UNVS_DONE;
				end else if (TXT_START && idx_ok) begin
					state_nxt = UNVS_TEXT;
				end
			end
			UNVS_NREAD: state_nxt = UNVS_NWAIT;
			UNVS_NWAIT: state_nxt = UNVS_DONE;
			UNVS_TEXT: begin
				// Advance; overflow past last location aborts
				if (need_nul) begin
					state_nxt = at_end ? UNVS_IDLE : UNVS_TNUL;
				end else if (str_end) begin
					state_nxt = UNVS_DONE;
				end else if (chunk_full && at_end) begin
					state_nxt = UNVS_IDLE;
				end
			end
			UNVS_TNUL: state_nxt = UNVS_DONE;
			default: state_nxt = UNVS_IDLE;
		endcase
	end

	wire txt_abort = (state_r == UNVS_TEXT) && (state_nxt == UNVS_IDLE);
	wire bad_req = idle && !IDX_WR && (NUM_RD || NUM_WR || TXT_START) && !idx_ok;
	// Written index never echoes as the success code
	wire [IDX_WIDTH-1:0] idx_echo = (IDX_WDATA == IDX_SUCCESS) ? IDX_RESET : IDX_WDATA;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_r <= UNVS_IDLE;
			idx_r <= IDX_RESET;
		end else begin
			state_r <= state_nxt;
			if (IDX_WR && idle) begin
				idx_r <= IDX_WDATA;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			addr_r <= 5'h00;
			pos_r <= 2'h0;
			chunk_r <= WORD_ZERO;
		end else if (idle) begin
			addr_r <= sel_addr;
			pos_r <= 2'h0;
			chunk_r <= WORD_ZERO;
		end else if (txt_we) begin
			addr_r <= addr_inc;
			pos_r <= 2'h0;
			chunk_r <= WORD_ZERO;
		end else if (char_take) begin
			pos_r <= pos_r + 2'h1;
			chunk_r <= chunk_nxt;
		end
	end

	// Index port readback: minus one after success
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			idx_out_r <= IDX_RESET;
		end else if (IDX_WR && idle) begin
			idx_out_r <= idx_echo;
		end else if (state_nxt == UNVS_DONE && state_r != UNVS_DONE) begin
			idx_out_r <= IDX_SUCCESS;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			num_out_r <= WORD_ZERO;
			num_vld_r <= 1'b0;
		end else begin
			num_vld_r <= state_r == UNVS_NWAIT;
			if (state_r == UNVS_NWAIT) begin
				num_out_r <= rd_word;
			end
		end
	end

	// Error flag for bad index or overflow
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			err_r <= 1'b0;
			busy_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			busy_r <= !((state_nxt == UNVS_IDLE) || (state_nxt == UNVS_DONE));
			ready_r <= state_nxt == UNVS_TEXT;
			if (bad_req || txt_abort) begin
				err_r <= 1'b1;
			end else if (IDX_WR && idle) begin
				err_r <= !idx_in_ok;
			end
		end
	end

	assign IDX_RDATA = idx_out_r;
	assign NUM_RDATA = num_out_r;
	assign NUM_RVALID = num_vld_r;
	assign TXT_READY = ready_r;
	assign BUSY = busy_r;
	assign ERR = err_r;

	bad_no_success_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(IDX_WR && idle && !idx_in_ok) |=> (IDX_RDATA != IDX_SUCCESS)[*2])
		else $error("success shown for bad index");
	bad_no_write_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(idle && !idx_ok && !IDX_WR) |-> !mem_we ##1 (!mem_we && !BUSY))
		else $error("write with bad index");
	// Numeric write targets the selected location
	num_write_addr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		num_we |-> (mem_wa == sel_addr && mem_wd == NUM_WDATA))
		else $error("numeric write wrong target");
	// Numeric write shows success next cycle
	num_success_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(num_we && !IDX_WR) |=> (IDX_RDATA == IDX_SUCCESS))
		else $error("no success after numeric write");
	// Read answer three cycles after request
	num_read_lat_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(idle && NUM_RD && !IDX_WR && idx_ok) |=> ##2 NUM_RVALID)
		else $error("numeric read answer late");
	// Full final chunk followed by terminator write
	nul_follow_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(need_nul && !at_end) |=> (nul_we && mem_wd == WORD_ZERO && mem_wa == $past(addr_inc)))
		else $error("terminator location missing");
	// Chunk write steps to next location
	chunk_step_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(txt_we && !str_end) |=> (addr_r == $past(addr_inc)))
		else $error("text location did not advance");
	txt_success_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		(str_end && !need_nul) |=> (IDX_RDATA == IDX_SUCCESS))
		else $error("no success after text write");
	num_read_c: cover property (@(posedge SYS_CLK) disable iff (RST) NUM_RVALID);
	long_text_c: cover property (@(posedge SYS_CLK) disable iff (RST) txt_we ##[1:20] nul_we);
	bad_idx_c: cover property (@(posedge SYS_CLK) disable iff (RST) bad_req);
endmodule : unvs_store

/* File: tb/test_unvs_store.sv */
// Self-checking bench for the user register store
`timescale 1ns/10ps
module test_unvs_store
	import unvs_pkg::*;
;
	logic SYS_CLK, RST, IDX_WR, NUM_WR, NUM_RD, TXT_START, TXT_VALID, TXT_LAST;
	logic [IDX_WIDTH-1:0] IDX_WDATA, IDX_RDATA;
	logic [NUM_WIDTH-1:0] NUM_WDATA, NUM_RDATA;
	logic [CHAR_WIDTH-1:0] TXT_CHAR;
	logic NUM_RVALID, TXT_READY, BUSY, ERR;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	unvs_store unvs_store_i (.SYS_CLK(SYS_CLK), .RST(RST), .IDX_WR(IDX_WR),
		.IDX_WDATA(IDX_WDATA), .IDX_RDATA(IDX_RDATA), .NUM_WR(NUM_WR),
		.NUM_WDATA(NUM_WDATA), .NUM_RD(NUM_RD), .NUM_RDATA(NUM_RDATA),
		.NUM_RVALID(NUM_RVALID), .TXT_START(TXT_START), .TXT_VALID(TXT_VALID),
		.TXT_CHAR(TXT_CHAR), .TXT_LAST(TXT_LAST), .TXT_READY(TXT_READY),
		.BUSY(BUSY), .ERR(ERR));
	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	// Hang guard
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic tick;
		@(posedge SYS_CLK);
		#1;
	endtask : tick
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic idle;
		for (int k = 0; k < 50 && BUSY !== 1'b0; k++) tick();
	endtask : idle
	task automatic set_idx(input logic [7:0] i);
		idle();
		IDX_WR = 1'b1;
		IDX_WDATA = i;
		tick();
		IDX_WR = 1'b0;
	endtask : set_idx
	task automatic num_wr(input logic [7:0] i, input logic [31:0] v, input logic ok);
		set_idx(i);
		if (ok) check(IDX_RDATA, i);
		NUM_WR = 1'b1;
		NUM_WDATA = v;
		tick();
		NUM_WR = 1'b0;
		check(IDX_RDATA === IDX_SUCCESS, ok);
		check(ERR, !ok);
	endtask : num_wr
	task automatic num_rd(input logic [7:0] i, input logic [31:0] exp);
		int k;
		set_idx(i);
		NUM_RD = 1'b1;
		tick();
		NUM_RD = 1'b0;
		for (k = 0; k < 8 && NUM_RVALID !== 1'b1; k++) tick();
		check(NUM_RVALID, 1'b1);
		check(k, 2);
		check(NUM_RDATA, exp);
		check(IDX_RDATA, IDX_SUCCESS);
		check(BUSY, 1'b0);
	endtask : num_rd
	task automatic txt(input logic [7:0] i, input logic [63:0] s, input int n, input logic ok);
		set_idx(i);
		TXT_START = 1'b1;
		tick();
		TXT_START = 1'b0;
		for (int c = 0; c < n; c++) begin
			TXT_VALID = 1'b1;
			TXT_CHAR = s[8*c +: 8];
			TXT_LAST = (c == n - 1);
			for (int k = 0; k < 8 && TXT_READY !== 1'b1; k++) tick();
			tick();
		end
		TXT_VALID = 1'b0;
		TXT_LAST = 1'b0;
		idle();
		check(IDX_RDATA === IDX_SUCCESS, ok);
		check(ERR, !ok);
	endtask : txt
	task automatic t_num;
		num_wr(8'h01, 32'hA5A50001, 1'b1);
		num_wr(8'h02, 32'h5A5A0002, 1'b1);
		num_wr(8'h20, 32'hC3C30020, 1'b1);
		num_rd(8'h01, 32'hA5A50001);
		num_rd(8'h02, 32'h5A5A0002);
		num_rd(8'h20, 32'hC3C30020);
	endtask : t_num
	task automatic t_bad;
		num_wr(8'h00, 32'hDEAD0000, 1'b0);
		num_wr(8'h21, 32'hDEAD0021, 1'b0);
		num_wr(8'hFF, 32'hDEAD00FF, 1'b0);
		num_rd(8'h01, 32'hA5A50001);
		num_rd(8'h20, 32'hC3C30020);
	endtask : t_bad
	task automatic t_txt4;
		num_wr(8'h06, 32'hFFFFFFFF, 1'b1);
		num_wr(8'h07, 32'h0707BEEF, 1'b1);
		txt(8'h05, 64'h44434241, 4, 1'b1);
		num_rd(8'h05, 32'h44434241);
		num_rd(8'h06, 32'h00000000);
		num_rd(8'h07, 32'h0707BEEF);
	endtask : t_txt4
	task automatic t_txt7;
		num_wr(8'h0B, 32'h12345678, 1'b1);
		txt(8'h0A, 64'h00464544434241, 7, 1'b1);
		num_rd(8'h0A, 32'h44434241);
		num_rd(8'h0B, 32'h00004645);
		txt(8'h0C, 64'h5A5958, 3, 1'b1);
		num_rd(8'h0C, 32'h005A5958);
	endtask : t_txt7
	task automatic t_ovf;
		txt(8'h20, 64'h4544434241, 5, 1'b0);
		num_rd(8'h20, 32'h44434241);
	endtask : t_ovf
	task automatic t_rst;
		RST = 1'b1;
		repeat (3) tick();
		RST = 1'b0;
		check(IDX_RDATA, IDX_RESET);
		num_rd(8'h05, 32'h44434241);
		num_rd(8'h02, 32'h5A5A0002);
	endtask : t_rst
	task automatic stop_test;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	initial begin
		{RST, IDX_WR, NUM_WR, NUM_RD, TXT_START, TXT_VALID, TXT_LAST} = 7'h40;
		IDX_WDATA = 8'h00;
		NUM_WDATA = 32'h00000000;
		TXT_CHAR = 8'h00;
		repeat (3) tick();
		RST = 1'b0;
		t_num();
		t_bad();
		t_txt4();
		t_txt7();
		t_ovf();
		t_rst();
		stop_test();
	end
endmodule : test_unvs_store
